// ---- core/counter_trio_pkg.sv ----
package counter_trio_pkg;

  // ----------------------------------------------------------------------
  // Widths, clocking and mode codes
  // ----------------------------------------------------------------------
  localparam int unsigned count_width = 16;
  localparam int unsigned num_counters = 3;
  localparam int unsigned ref_clk_hz = 100_000_000;
  localparam int unsigned int_clk_hz = 2_000_000;
  // Half period of the internal 2 MHz tick, in reference clock cycles
  localparam int unsigned int_half_cycles = ref_clk_hz / (2 * int_clk_hz);
  localparam logic [15:0] reload_reset = 16'hffff;

  typedef enum logic [2:0] {
    mode_event,
    mode_level_gate,
    mode_edge_gate,
    mode_square,
    mode_pulse,
    mode_one_shot
  } cnt_mode_e;

  // Software control for one counter
  typedef struct packed {
    cnt_mode_e mode;
    logic [15:0] reload;
    logic load;
    logic latch;
    logic falling;
  } cnt_ctrl_s;

  // Pin side of one counter
  typedef struct packed {
    logic gate;
    logic clk;
  } cnt_pins_s;

endpackage : counter_trio_pkg

// ---- core/down_counter.sv ----
module down_counter #(
  parameter int unsigned width = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic tick,
  input wire logic gate,
  input wire counter_trio_pkg::cnt_ctrl_s ctrl,
  output logic [width-1:0] count_r,
  output logic [width-1:0] latched_r,
  output logic out_r
);

  initial begin
    if (width < 2 || width > 16) $error("down_counter width out of range");
  end

  logic gate_q_r;
  logic armed_r;
  logic running_r;
  logic gate_rise;
  logic [width-1:0] reload;

  assign reload = ctrl.reload[width-1:0];
  assign gate_rise = gate && !gate_q_r;

  // ----------------------------------------------------------------------
  // Gate sampling and arming, on the count clock edge only
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gate_q_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        gate_q_r <= gate;
      end
      if (ctrl.load) begin
        armed_r <= 1'b0;
      end else if (tick && gate_rise) begin
        armed_r <= 1'b1;
      end
    end
  end

  always_comb begin
    case (ctrl.mode)
      counter_trio_pkg::mode_event: running_r = gate;
      counter_trio_pkg::mode_level_gate: running_r = gate;
      counter_trio_pkg::mode_edge_gate: running_r = armed_r || gate_rise;
      counter_trio_pkg::mode_one_shot: running_r = armed_r || gate_rise;
      default: running_r = gate;
    endcase
  end

  // ----------------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_r <= '1;
    end else if (ce) begin
      if (ctrl.load) begin
        count_r <= reload;
      end else if (tick && running_r) begin
        // Periodic modes reload at the terminal count
        if ((ctrl.mode == counter_trio_pkg::mode_square ||
             ctrl.mode == counter_trio_pkg::mode_pulse) && count_r <= width'(1)) begin
          count_r <= reload;
        end else begin
          count_r <= count_r - width'(1);
        end
      end
    end
  end

  // Snapshot for software; the count never stops for it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latched_r <= '0;
    end else if (ce && ctrl.latch) begin
      latched_r <= count_r;
    end
  end

  // ----------------------------------------------------------------------
  // Output waveform, changed only on the count clock edge or by a load
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_r <= 1'b1;
    end else if (ce) begin
      if (ctrl.load) begin
        out_r <= 1'b1;
      end else if (tick) begin
        case (ctrl.mode)
          counter_trio_pkg::mode_square: begin
            if (running_r) out_r <= (count_r > (reload >> 1)) ? 1'b1 : 1'b0;
          end
          counter_trio_pkg::mode_pulse: begin
            if (running_r) out_r <= (count_r != width'(2));
          end
          counter_trio_pkg::mode_one_shot: begin
            // Low from trigger to terminal count, active low
            if (running_r && count_r > width'(1)) out_r <= 1'b0;
            else out_r <= 1'b1;
          end
          default: out_r <= (count_r == '0) ? 1'b1 : 1'b0;
        endcase
      end
    end
  end

  a_load_takes: assert property (@(posedge ref_clk) disable iff (srst)
    ce && ctrl.load |=> count_r == $past(reload)) else $error("load not taken");
  a_level_hold: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !ctrl.load && ctrl.mode == counter_trio_pkg::mode_level_gate && !gate
    |=> count_r == $past(count_r)) else $error("counted with gate low");
  a_count_step: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !ctrl.load && tick && gate && ctrl.mode == counter_trio_pkg::mode_event
    |=> count_r == $past(count_r) - width'(1)) else $error("count step wrong");
  a_no_tick_out: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !tick && !ctrl.load |=> $stable(out_r)) else $error("out moved off edge");
  a_edge_arm: assert property (@(posedge ref_clk) disable iff (srst)
    ce && tick && gate_rise && !ctrl.load |=> armed_r) else $error("edge not armed");
  a_latch_val: assert property (@(posedge ref_clk) disable iff (srst)
    ce && ctrl.latch |=> latched_r == $past(count_r)) else $error("latch wrong");
  a_event_gate: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !ctrl.load && ctrl.mode == counter_trio_pkg::mode_event && !gate
    |=> $stable(count_r)) else $error("event counted gated off");
  a_shot_idle: assert property (@(posedge ref_clk) disable iff (srst)
    ce && ctrl.load |=> out_r) else $error("output not idle after load");
  c_one_shot: cover property (@(posedge ref_clk)
    ctrl.mode == counter_trio_pkg::mode_one_shot && !out_r);
  c_square: cover property (@(posedge ref_clk)
    ctrl.mode == counter_trio_pkg::mode_square && $fell(out_r));
  c_wrap: cover property (@(posedge ref_clk) count_r == '0);

endmodule : down_counter

// ---- core/general_purpose_counter_trio.sv ----
// How it works
// - Three independent counters, gate clock output each
// - First counter runs on internal 2 MHz
// - Second, third counters use external pins
// - Pulse and square modes drive output waveform
// - Event mode counts edges, software reads count
// - Gate enables or suspends event counting
// - Level gate: decrement only while gate high
// - Edge gate: start after gate rising edge
// - Count is loaded value minus counted periods
// - One-shot output pulse is active low
// - Gate sampled, output changed on count clock edge (rise, or fall if selected on second and third counters; first counter always rise) or load
module general_purpose_counter_trio #(
  parameter int unsigned width = counter_trio_pkg::count_width
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic first_counter_gate,
  input wire counter_trio_pkg::cnt_pins_s second_counter_pins,
  input wire counter_trio_pkg::cnt_pins_s third_counter_pins,
  input wire counter_trio_pkg::cnt_ctrl_s first_counter_ctrl,
  input wire counter_trio_pkg::cnt_ctrl_s second_counter_ctrl,
  input wire counter_trio_pkg::cnt_ctrl_s third_counter_ctrl,
  output logic [width-1:0] first_counter_value,
  output logic [width-1:0] second_counter_value,
  output logic [width-1:0] third_counter_value,
  output logic first_counter_out,
  output logic second_counter_out,
  output logic third_counter_out
);

  initial begin
    if (width != counter_trio_pkg::count_width) $error("width must be 16");
  end

  // ----------------------------------------------------------------------
  // Internal 2 MHz tick and pin clock edge detection
  // ----------------------------------------------------------------------
  logic [7:0] div_r;
  logic int_clk_r;
  logic int_tick;
  logic clk1_q_r;
  logic clk2_q_r;
  logic tick1;
  logic tick2;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_r <= 8'h00;
      int_clk_r <= 1'b0;
    end else if (ce) begin
      if (div_r == 8'(counter_trio_pkg::int_half_cycles - 1)) begin
        div_r <= 8'h00;
        int_clk_r <= !int_clk_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  assign int_tick = ce && !int_clk_r &&
                    div_r == 8'(counter_trio_pkg::int_half_cycles - 1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clk1_q_r <= 1'b1;
      clk2_q_r <= 1'b1;
    end else if (ce) begin
      clk1_q_r <= second_counter_pins.clk;
      clk2_q_r <= third_counter_pins.clk;
    end
  end

  // Falling edges counted on request, needed for frequency measurement
  function automatic logic edge_of(input logic now, input logic was, input logic fall);
    edge_of = fall ? (was && !now) : (now && !was);
  endfunction : edge_of

  assign tick1 = edge_of(second_counter_pins.clk, clk1_q_r, second_counter_ctrl.falling);
  assign tick2 = edge_of(third_counter_pins.clk, clk2_q_r, third_counter_ctrl.falling);

  // ----------------------------------------------------------------------
  // Three independent counters
  // ----------------------------------------------------------------------
  logic [width-1:0] lat0;
  logic [width-1:0] lat1;
  logic [width-1:0] lat2;

  down_counter #(.width(width)) u_first (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .tick(int_tick),
    .gate(first_counter_gate), .ctrl(first_counter_ctrl),
    .count_r(), .latched_r(lat0), .out_r(first_counter_out)
  );
  down_counter #(.width(width)) u_second (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .tick(tick1),
    .gate(second_counter_pins.gate), .ctrl(second_counter_ctrl),
    .count_r(), .latched_r(lat1), .out_r(second_counter_out)
  );
  down_counter #(.width(width)) u_third (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .tick(tick2),
    .gate(third_counter_pins.gate), .ctrl(third_counter_ctrl),
    .count_r(), .latched_r(lat2), .out_r(third_counter_out)
  );

  assign first_counter_value = lat0;
  assign second_counter_value = lat1;
  assign third_counter_value = lat2;

  a_tick_period: assert property (@(posedge ref_clk) disable iff (srst || !ce)
    int_tick |=> !int_tick [*8]) else $error("internal tick too fast");
  c_ext_tick: cover property (@(posedge ref_clk) tick1 && tick2);
  c_int_tick: cover property (@(posedge ref_clk) int_tick);

endmodule : general_purpose_counter_trio

// ---- bench/pin_side_model.sv ----
module pin_side_model (
  input wire logic ref_clk,
  output counter_trio_pkg::cnt_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Connector gate and clock, pulled up when idle
  // ----------------------------------------
  initial pins = 2'b11;
  task automatic set_gate(input logic level);
    @(posedge ref_clk);
    #1 pins.gate = level;
  endtask : set_gate
  // Clock rests high between bursts, as the pull-up leaves it
  task automatic edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge ref_clk);
      #1 pins.clk = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 pins.clk = 1'b1;
    end
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : edges
endmodule : pin_side_model

// ---- bench/general_purpose_counter_trio_tb.sv ----
module general_purpose_counter_trio_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus, scenarios and verdict
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic g0 = 1'b0;
  counter_trio_pkg::cnt_ctrl_s ctrl [3];
  counter_trio_pkg::cnt_pins_s p1, p2;
  logic [15:0] val [3];
  logic [2:0] outs;
  logic [15:0] v, w;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  general_purpose_counter_trio i_general_purpose_counter_trio (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .first_counter_gate(g0),
    .second_counter_pins(p1), .third_counter_pins(p2),
    .first_counter_ctrl(ctrl[0]), .second_counter_ctrl(ctrl[1]),
    .third_counter_ctrl(ctrl[2]), .first_counter_value(val[0]),
    .second_counter_value(val[1]), .third_counter_value(val[2]),
    .first_counter_out(outs[0]), .second_counter_out(outs[1]),
    .third_counter_out(outs[2])
  );
  pin_side_model i_pin_side_model (.ref_clk(ref_clk), .pins(p1));
  pin_side_model i_pin_side_model_2 (.ref_clk(ref_clk), .pins(p2));

  initial forever #5 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic load(input int i, input counter_trio_pkg::cnt_mode_e m,
                      input logic [15:0] r, input logic f);
    ctrl[i].mode = m;
    ctrl[i].reload = r;
    ctrl[i].falling = f;
    ctrl[i].load = 1'b1;
    @(posedge ref_clk);
    #1 ctrl[i].load = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : load

  // Latch is a snapshot, so the count keeps running behind it
  task automatic read(input int i, output logic [15:0] r);
    ctrl[i].latch = 1'b1;
    @(posedge ref_clk);
    #1 ctrl[i].latch = 1'b0;
    @(posedge ref_clk);
    #1 r = val[i];
  endtask : read

  task automatic t_reset();
    for (int i = 0; i < 3; i++) check(val[i], 16'h0000);
    check({13'h0000, outs}, 16'h0007);
    read(1, v);
    check(v, 16'hffff);
    $display("test reset done");
  endtask : t_reset

  task automatic t_event();
    load(1, counter_trio_pkg::mode_event, 16'h800a, 1'b0);
    i_pin_side_model.set_gate(1'b1);
    i_pin_side_model.edges(3);
    i_pin_side_model.set_gate(1'b0);
    i_pin_side_model.edges(2);
    read(1, v);
    check(v, 16'h8007);
    i_pin_side_model.set_gate(1'b1);
    // Clock enable low must swallow pin edges
    ce = 1'b0;
    i_pin_side_model.edges(2);
    ce = 1'b1;
    read(1, v);
    check(v, 16'h8007);
    i_pin_side_model.edges(1);
    read(1, v);
    check(v, 16'h8006);
    $display("test event done");
  endtask : t_event

  task automatic t_level();
    i_pin_side_model_2.set_gate(1'b0);
    load(2, counter_trio_pkg::mode_level_gate, 16'h7f65, 1'b1);
    i_pin_side_model_2.set_gate(1'b1);
    i_pin_side_model_2.edges(4);
    i_pin_side_model_2.set_gate(1'b0);
    read(2, v);
    check(v, 16'h7f61);
    i_pin_side_model_2.edges(3);
    read(2, v);
    check(v, 16'h7f61);
    $display("test level done");
  endtask : t_level

  task automatic t_edge();
    i_pin_side_model.set_gate(1'b0);
    load(1, counter_trio_pkg::mode_edge_gate, 16'h5514, 1'b0);
    i_pin_side_model.edges(3);
    read(1, v);
    check(v, 16'h5514);
    i_pin_side_model.set_gate(1'b1);
    i_pin_side_model.edges(2);
    read(1, v);
    check(v, 16'h5512);
    $display("test edge done");
  endtask : t_edge

  // Latches 500 cycles apart span exactly ten internal ticks
  task automatic t_internal();
    load(0, counter_trio_pkg::mode_event, 16'h2b80, 1'b0);
    g0 = 1'b1;
    read(0, v);
    repeat (498) @(posedge ref_clk);
    #1;
    read(0, w);
    check(v - w, 16'h000a);
    read(1, v);
    check(v, 16'h5512);
    $display("test internal done");
  endtask : t_internal

  task automatic t_waves();
    i_pin_side_model_2.set_gate(1'b1);
    load(2, counter_trio_pkg::mode_square, 16'h0008, 1'b0);
    i_pin_side_model_2.edges(1);
    check({15'h0000, outs[2]}, 16'h0001);
    i_pin_side_model_2.edges(4);
    check({15'h0000, outs[2]}, 16'h0000);
    i_pin_side_model_2.set_gate(1'b0);
    // The gate is only seen low at a count clock edge
    i_pin_side_model_2.edges(1);
    load(2, counter_trio_pkg::mode_one_shot, 16'h0005, 1'b0);
    i_pin_side_model_2.set_gate(1'b1);
    i_pin_side_model_2.edges(2);
    check({15'h0000, outs[2]}, 16'h0000);
    i_pin_side_model_2.edges(3);
    check({15'h0000, outs[2]}, 16'h0001);
    $display("test waves done");
  endtask : t_waves

  initial begin
    for (int i = 0; i < 3; i++) ctrl[i] = '0;
    repeat (8) @(posedge ref_clk);
    #1 srst = 1'b0;
    t_reset();
    t_event();
    t_level();
    t_edge();
    t_internal();
    t_waves();
    print_verdict();
  end
endmodule : general_purpose_counter_trio_tb
